/* File: logic/simple_i2c_pkg.sv */
// constants, state encoding and prescaler table for the simple two-wire master
// assumes one 40 MHz peripheral clock and open-drain pads with external pull-ups

package simple_i2c_pkg;

	// ------------------------------------------------------------------
	// widths and prescaler
	// ------------------------------------------------------------------
	localparam int DLY_W = 5;
	localparam int BAUD_W = 8;
	localparam int PRESC_W = 6;
	localparam int PHASE_W = 9;
	localparam int BITCNT_W = 4;
	localparam logic [BITCNT_W-1:0] LAST_BIT = 4'h8;
	localparam logic [PRESC_W-1:0] PRESC_DIV1 = 6'h00;
	localparam logic [PRESC_W-1:0] PRESC_DIV4 = 6'h03;
	localparam logic [PRESC_W-1:0] PRESC_DIV16 = 6'h0F;
	localparam logic [PRESC_W-1:0] PRESC_DIV64 = 6'h3F;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic LINE_RELEASED = 1'b0;
	localparam logic [8:0] SHIFT_RESET = 9'h1FF;

	// ------------------------------------------------------------------
	// controller states, gray along start, bit and restart paths
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_START_HOLD = 4'h1,
		ST_BIT_LOW = 4'h3,
		ST_BIT_HIGH = 4'h2,
		ST_RS_LOW = 4'h6,
		ST_RS_WAIT = 4'h7,
		ST_RS_SETUP = 4'h5,
		ST_RS_HOLD = 4'h4,
		ST_SP_LOW = 4'hC,
		ST_SP_WAIT = 4'hD,
		ST_SP_SETUP = 4'hF
	} master_state_e;

endpackage

/* File: logic/line_sync_filter.sv */
// two-flop synchroniser plus three-sample noise filter for one bus line
// assumes the raw pin is asynchronous to clk_i and idles high
`timescale 1ns/1ps

module line_sync_filter
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// line
	input wire logic line_i,
	output logic line_filt_o
);

	logic sync1_q;
	logic sync2_q;
	logic hist1_q;
	logic hist2_q;

	// ------------------------------------------------------------------
	// synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end
		else
		begin
			sync1_q <= line_i;
			sync2_q <= sync1_q;
		end
	end

	// ------------------------------------------------------------------
	// filter: level accepted after three equal samples
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hist1_q <= 1'b1;
			hist2_q <= 1'b1;
			line_filt_o <= 1'b1;
		end
		else
		begin
			hist1_q <= sync2_q;
			hist2_q <= hist1_q;
			if (sync2_q == hist1_q && hist1_q == hist2_q)
			begin
				line_filt_o <= hist2_q;
			end
		end
	end

endmodule

/* File: logic/simple_i2c_master.sv */
// simple two-wire master: conditions, 9-bit frames, clock sync, data delay
// assumes open-drain pads with pull-ups; control bits held stable by software
`timescale 1ns/1ps

module simple_i2c_master
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// configuration
	input wire logic clock_sync_enable_i,
	input wire logic [simple_i2c_pkg::DLY_W-1:0] data_output_delay_count_i,
	input wire logic [1:0] clock_prescale_select_i,
	input wire logic [simple_i2c_pkg::BAUD_W-1:0] baud_divisor_i,
	input wire logic interrupt_mode_select_i,
	// condition requests
	input wire logic start_request_i,
	input wire logic restart_request_i,
	input wire logic stop_request_i,
	output logic start_request_o,
	output logic restart_request_o,
	output logic stop_request_o,
	// frame data
	input wire logic frame_start_i,
	input wire logic [7:0] tx_data_i,
	input wire logic ack_out_i,
	input wire logic frame_is_rx_i,
	output logic [7:0] rx_data_o,
	output logic ack_received_o,
	output logic busy_o,
	// event pulses
	output logic condition_status_irq_o,
	output logic transmit_irq_o,
	output logic receive_irq_o,
	output logic ack_irq_o,
	output logic nack_irq_o,
	// bus pins
	input wire logic bus_clock_line_i,
	output logic bus_clock_line_o,
	output logic bus_clock_line_oe_o,
	input wire logic bus_data_line_i,
	output logic bus_data_line_o,
	output logic bus_data_line_oe_o
);
	import simple_i2c_pkg::*;

	master_state_e state_q;
	master_state_e state_d;
	logic scl_filt;
	logic sda_filt;
	logic [PRESC_W-1:0] presc_q;
	logic tick;
	logic [PHASE_W-1:0] phase_q;
	logic half_done;
	logic phase_hold;
	logic [DLY_W-1:0] dly_cnt_q;
	logic dly_busy_q;
	logic sda_pend_q;
	logic scl_low_q;
	logic sda_low_q;
	logic [8:0] shift_q;
	logic [8:0] rx_q;
	logic [BITCNT_W-1:0] bit_q;
	logic rx_frame_q;
	logic eff_clk;
	logic eff_clk_q;
	logic sample;
	logic low_load;
	logic frame_done;
	logic cond_done;

	// ------------------------------------------------------------------
	// line inputs
	// ------------------------------------------------------------------
	line_sync_filter u_scl_filter (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.line_i(bus_clock_line_i),
		.line_filt_o(scl_filt)
	);

	line_sync_filter u_sda_filter (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.line_i(bus_data_line_i),
		.line_filt_o(sda_filt)
	);

	// ------------------------------------------------------------------
	// baud rate generator tick
	// ------------------------------------------------------------------
	function automatic logic [PRESC_W-1:0] presc_limit(input logic [1:0] sel);
		case (sel)
			2'h0: presc_limit = PRESC_DIV1;
			2'h1: presc_limit = PRESC_DIV4;
			2'h2: presc_limit = PRESC_DIV16;
			default: presc_limit = PRESC_DIV64;
		endcase
	endfunction

	function automatic logic is_low_phase(input master_state_e st);
		is_low_phase = (st == ST_BIT_LOW) || (st == ST_RS_LOW) || (st == ST_SP_LOW);
	endfunction

	assign tick = (presc_q >= presc_limit(clock_prescale_select_i));

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			presc_q <= '0;
		else if (tick)
			presc_q <= '0;
		else
			presc_q <= presc_q + 6'h01;
	end

	// ------------------------------------------------------------------
	// half-bit phase counter
	// ------------------------------------------------------------------
	assign half_done = (phase_q > {1'b0, baud_divisor_i});
	assign phase_hold = (state_q == ST_BIT_HIGH) && clock_sync_enable_i && !scl_filt;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			phase_q <= '0;
		else if (state_d != state_q)
			phase_q <= '0;
		else if (tick && !half_done && !phase_hold && state_q != ST_IDLE)
			phase_q <= phase_q + 9'h001;
	end

	// ------------------------------------------------------------------
	// effective clock for data sampling
	// ------------------------------------------------------------------
	assign eff_clk = !scl_low_q && (clock_sync_enable_i ? scl_filt : 1'b1);
	assign sample = eff_clk && !eff_clk_q && (state_q == ST_BIT_HIGH);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			eff_clk_q <= 1'b1;
		else
			eff_clk_q <= eff_clk;
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (start_request_o)
					state_d = ST_START_HOLD;
				else if (restart_request_o)
					state_d = ST_RS_LOW;
				else if (stop_request_o)
					state_d = ST_SP_LOW;
				else if (frame_start_i)
					state_d = ST_BIT_LOW;
			end
			ST_START_HOLD:
				if (half_done) state_d = ST_IDLE;
			ST_BIT_LOW:
				if (half_done && !dly_busy_q) state_d = ST_BIT_HIGH;
			ST_BIT_HIGH:
				if (half_done) state_d = (bit_q == LAST_BIT) ? ST_IDLE : ST_BIT_LOW;
			ST_RS_LOW:
				if (half_done && !dly_busy_q) state_d = ST_RS_WAIT;
			ST_RS_WAIT:
				if (scl_filt) state_d = ST_RS_SETUP;
			ST_RS_SETUP:
				if (half_done) state_d = ST_RS_HOLD;
			ST_RS_HOLD:
				if (half_done) state_d = ST_IDLE;
			ST_SP_LOW:
				if (half_done && !dly_busy_q) state_d = ST_SP_WAIT;
			ST_SP_WAIT:
				if (scl_filt) state_d = ST_SP_SETUP;
			ST_SP_SETUP:
				if (half_done) state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	assign low_load = (state_d != state_q) && is_low_phase(state_d);
	assign frame_done = (state_q == ST_BIT_HIGH) && (state_d == ST_IDLE);
	assign cond_done = (state_d == ST_IDLE) && ((state_q == ST_START_HOLD) ||
		(state_q == ST_RS_HOLD) || (state_q == ST_SP_SETUP));

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------------
	// request bits: set wins over completion clear
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			start_request_o <= 1'b0;
			restart_request_o <= 1'b0;
			stop_request_o <= 1'b0;
		end
		else
		begin
			if (start_request_i)
				start_request_o <= 1'b1;
			else if (cond_done && state_q == ST_START_HOLD)
				start_request_o <= 1'b0;
			if (restart_request_i)
				restart_request_o <= 1'b1;
			else if (cond_done && state_q == ST_RS_HOLD)
				restart_request_o <= 1'b0;
			if (stop_request_i)
				stop_request_o <= 1'b1;
			else if (cond_done && state_q == ST_SP_SETUP)
				stop_request_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// clock line drive
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			scl_low_q <= LINE_RELEASED;
		else if (state_d != state_q)
			scl_low_q <= is_low_phase(state_d) || (state_d == ST_IDLE && state_q != ST_SP_SETUP);
	end

	// ------------------------------------------------------------------
	// data line drive with delay after clock falls
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sda_low_q <= LINE_RELEASED;
			sda_pend_q <= 1'b0;
			dly_cnt_q <= '0;
			dly_busy_q <= 1'b0;
		end
		else if (low_load)
		begin
			dly_cnt_q <= data_output_delay_count_i;
			dly_busy_q <= 1'b1;
			sda_pend_q <= (state_d == ST_SP_LOW) || (state_d == ST_BIT_LOW &&
				!((state_q == ST_IDLE) ? tx_data_i[7] : shift_q[8]));
		end
		else if (state_d == ST_START_HOLD && state_q == ST_IDLE)
			sda_low_q <= 1'b1;
		else if (state_d == ST_RS_HOLD && state_q == ST_RS_SETUP)
			sda_low_q <= 1'b1;
		else if (cond_done && state_q == ST_SP_SETUP)
			sda_low_q <= 1'b0;
		else if (dly_busy_q && tick)
		begin
			if (dly_cnt_q == '0)
			begin
				sda_low_q <= sda_pend_q;
				dly_busy_q <= 1'b0;
			end
			else
				dly_cnt_q <= dly_cnt_q - 5'h01;
		end
	end

	// pins only pull low or release
	assign bus_clock_line_o = 1'b0;
	assign bus_clock_line_oe_o = scl_low_q;
	assign bus_data_line_o = 1'b0;
	assign bus_data_line_oe_o = sda_low_q;
	assign busy_o = (state_q != ST_IDLE);

	// ------------------------------------------------------------------
	// shift registers and bit count
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			shift_q <= SHIFT_RESET;
			rx_q <= '0;
			bit_q <= '0;
			rx_frame_q <= 1'b0;
		end
		else
		begin
			if (state_q == ST_IDLE && state_d == ST_BIT_LOW)
			begin
				shift_q <= {tx_data_i, ack_out_i};
				bit_q <= '0;
				rx_frame_q <= frame_is_rx_i;
			end
			else if (state_q == ST_BIT_LOW && state_d == ST_BIT_HIGH)
				shift_q <= {shift_q[7:0], 1'b1};
			else if (state_q == ST_BIT_HIGH && state_d == ST_BIT_LOW)
				bit_q <= bit_q + 4'h1;
			if (sample)
				rx_q <= {rx_q[7:0], sda_filt};
		end
	end

	// ------------------------------------------------------------------
	// frame results and event pulses
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_data_o <= '0;
			ack_received_o <= 1'b0;
			condition_status_irq_o <= 1'b0;
			transmit_irq_o <= 1'b0;
			receive_irq_o <= 1'b0;
			ack_irq_o <= 1'b0;
			nack_irq_o <= 1'b0;
		end
		else
		begin
			condition_status_irq_o <= cond_done;
			transmit_irq_o <= frame_done && interrupt_mode_select_i;
			receive_irq_o <= frame_done && interrupt_mode_select_i && rx_frame_q;
			ack_irq_o <= frame_done && !interrupt_mode_select_i && !rx_q[0];
			nack_irq_o <= frame_done && !interrupt_mode_select_i && rx_q[0];
			if (frame_done)
			begin
				rx_data_o <= rx_q[8:1];
				ack_received_o <= !rx_q[0];
			end
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_SYNC_HOLD: assert property (phase_hold |=> $stable(phase_q))
		else $error("high count advanced while clock pin low");
	AST_LAG: assert property ((state_q == ST_BIT_HIGH) && (state_d == state_q) &&
		clock_sync_enable_i && !scl_filt && phase_q == '0 |=> phase_q == '0)
		else $error("high count started before clock pin seen high");
	AST_SAMPLE_AND: assert property (sample && clock_sync_enable_i |-> scl_filt && !scl_low_q)
		else $error("data sampled without clock pin high");
	AST_WAIT_HIGH: assert property ((state_q == ST_RS_WAIT || state_q == ST_SP_WAIT) &&
		!scl_filt |=> state_q == $past(state_q))
		else $error("condition advanced while slave held clock low");
	AST_COND_IRQ: assert property ((state_q == ST_SP_SETUP) && half_done
		|=> condition_status_irq_o && !stop_request_o)
		else $error("stop completion not signalled");
	AST_DELAY_LOAD: assert property (low_load |=> dly_busy_q &&
		dly_cnt_q == $past(data_output_delay_count_i))
		else $error("data delay not loaded at clock fall");
	AST_DELAY_HOLD: assert property (dly_busy_q && dly_cnt_q != '0 && !low_load
		|=> $stable(sda_low_q))
		else $error("data changed before delay expired");
	AST_TX_IRQ: assert property (frame_done && interrupt_mode_select_i
		|=> transmit_irq_o && !ack_irq_o && !nack_irq_o)
		else $error("frame end without transmit interrupt");
	AST_ACK_SPLIT: assert property (frame_done && !interrupt_mode_select_i
		|=> (ack_irq_o != nack_irq_o) && !transmit_irq_o)
		else $error("ack or nack interrupt missing");
	AST_START_SEQ: assert property (state_q == ST_START_HOLD |-> sda_low_q ##0 !scl_low_q)
		else $error("start hold with wrong line levels");
	AST_OPEN_DRAIN: assert property (!bus_clock_line_o && !bus_data_line_o)
		else $error("pin driven high");

	COV_START: cover property (state_q == ST_START_HOLD ##[1:300] condition_status_irq_o);
	COV_STRETCH: cover property (phase_hold [*3]);
	COV_NACK: cover property (nack_irq_o);
	COV_STOP: cover property (state_q == ST_SP_WAIT ##1 state_q == ST_SP_SETUP);

endmodule

/* File: tb/i2c_slave_model.sv */
// behavioural two-wire slave: captures written bytes, returns read bytes, stretches clock
// assumes the bench builds wired-and lines with pull-ups from all output enables
`timescale 1ns/1ps

module i2c_slave_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// bus levels and pull-low enables
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_oe_o,
	output logic sda_oe_o,
	// behaviour control
	input wire logic read_mode_i,
	input wire logic nack_i,
	input wire logic hold_i,
	input wire logic [7:0] rd_byte_i,
	input wire logic [9:0] stretch_i,
	output logic [7:0] got_byte_o
);
	// ------------------------------------------------------------------
	// slot tracking, -1 after a start, -2 when not addressed
	// ------------------------------------------------------------------
	logic scl_q;
	logic sda_q;
	logic [7:0] sh_q;
	int slot_q;
	int hold_q;

	assign scl_oe_o = hold_i | (hold_q > 0);
	assign sda_oe_o = read_mode_i ? (slot_q >= 0 && slot_q < 8 && !rd_byte_i[7 - slot_q])
		: (slot_q == 8 && !nack_i);

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			slot_q <= -2;
			hold_q <= 0;
			sh_q <= 8'h00;
			got_byte_o <= 8'h00;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			if (hold_q > 0)
				hold_q <= hold_q - 1;
			if (scl_i && scl_q && sda_q && !sda_i)
				slot_q <= -1;
			else if (scl_i && scl_q && !sda_q && sda_i)
				slot_q <= -2;
			else if (scl_q && !scl_i && slot_q > -2)
			begin
				slot_q <= (slot_q == 8) ? 0 : slot_q + 1;
				hold_q <= int'(stretch_i);
			end
			else if (!scl_q && scl_i && slot_q >= 0)
			begin
				if (slot_q < 8)
					sh_q <= {sh_q[6:0], sda_i};
				else if (read_mode_i && sda_i)
					slot_q <= -2;
				else
					got_byte_o <= sh_q;
			end
		end
	end
endmodule

/* File: tb/simple_i2c_master_clock_sync_tb.sv */
// self-checking bench for the simple two-wire master with a slave model on the far side
// assumes a 40 MHz clock and pull-ups on both lines
`timescale 1ns/1ps

module simple_i2c_master_clock_sync_tb;
	import simple_i2c_pkg::*;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sync_en = 1'b0, mode = 1'b1, sreq = 1'b0, rreq = 1'b0, preq = 1'b0, fstart = 1'b0;
	logic ack_out = 1'b1, is_rx = 1'b0, rd_mode = 1'b0, nack = 1'b0, hold = 1'b0;
	logic [4:0] dly = 5'h0D;
	logic [1:0] presc = 2'h0;
	logic [7:0] baud = 8'h13, txd = 8'h00, rd_byte = 8'hFF, rx_data, got;
	logic [9:0] stretch = 10'h000;
	logic sreq_o, rreq_o, preq_o, ack_rx, busy, cirq, tirq, rirq, airq, nirq;
	logic scl, sda, scl_o, sda_o, m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, scl_p, sda_p;
	int fail_count = 0, check_count = 0, cyc = 0, t_fall = 0, dmin, dmax, d0, d1, d2, tk;
	logic [31:0] lfsr = 32'h99d7;
	logic [7:0] exp_q[$];
	int dtab[4] = '{13, 31, 4, 2};
	int btab[4] = '{19, 7, 3, 1};

	assign scl = !(m_scl_oe | s_scl_oe);
	assign sda = !(m_sda_oe | s_sda_oe);
	always #12.5 clk_i = ~clk_i;

	simple_i2c_master dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clock_sync_enable_i(sync_en),
		.data_output_delay_count_i(dly), .clock_prescale_select_i(presc),
		.baud_divisor_i(baud), .interrupt_mode_select_i(mode), .start_request_i(sreq),
		.restart_request_i(rreq), .stop_request_i(preq), .start_request_o(sreq_o),
		.restart_request_o(rreq_o), .stop_request_o(preq_o), .frame_start_i(fstart),
		.tx_data_i(txd), .ack_out_i(ack_out), .frame_is_rx_i(is_rx), .rx_data_o(rx_data),
		.ack_received_o(ack_rx), .busy_o(busy), .condition_status_irq_o(cirq),
		.transmit_irq_o(tirq), .receive_irq_o(rirq), .ack_irq_o(airq), .nack_irq_o(nirq),
		.bus_clock_line_i(scl), .bus_clock_line_o(scl_o), .bus_clock_line_oe_o(m_scl_oe),
		.bus_data_line_i(sda), .bus_data_line_o(sda_o), .bus_data_line_oe_o(m_sda_oe));

	i2c_slave_model slave (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
		.scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .read_mode_i(rd_mode), .nack_i(nack),
		.hold_i(hold), .rd_byte_i(rd_byte), .stretch_i(stretch), .got_byte_o(got));

	// data delay tracker: cycles from clock fall (or frame start) to a data change
	always @(negedge clk_i)
	begin
		cyc = cyc + 1;
		if (fstart || (m_scl_oe && !scl_p))
			t_fall = cyc;
		else if (m_scl_oe && m_sda_oe !== sda_p)
		begin
			dmin = (cyc - t_fall < dmin) ? cyc - t_fall : dmin;
			dmax = (cyc - t_fall > dmax) ? cyc - t_fall : dmax;
		end
		scl_p = m_scl_oe;
		sda_p = m_sda_oe;
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic tick;
		@(posedge clk_i);
		#2;
	endtask

	task automatic check_bit(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic check_range(input string nm, input int lo, input int hi, input int g);
		check_count++;
		if (g < lo || g > hi)
		begin
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
			fail_count++;
		end
	endtask

	task automatic wait_cirq(output int dur);
		dur = 0;
		while (cirq !== 1'b1 && dur < 20000)
		begin
			tick;
			dur++;
		end
	endtask

	// which: 0 start, 1 restart, 2 stop; lo is the least duration the sequence allows
	task automatic cond(input int which, input int lo);
		int dur;
		sreq = (which == 0);
		rreq = (which == 1);
		preq = (which == 2);
		tick;
		{sreq, rreq, preq} = 3'b000;
		check_bit("request_set", 1'b1, (which == 0) ? sreq_o : (which == 1) ? rreq_o : preq_o);
		wait_cirq(dur);
		check_range("cond_time", lo, 19999, dur);
		check_bit("request_clear", 1'b0, sreq_o | rreq_o | preq_o);
	endtask

	// d is the written byte or the byte the slave returns; nk asks for a NACK
	task automatic frame(input logic [7:0] d, input logic rx, input logic nk, output int dur);
		txd = rx ? 8'hFF : d;
		rd_byte = d;
		is_rx = rx;
		ack_out = rx ? nk : 1'b1;
		nack = nk;
		if (!rx)
			exp_q.push_back(d);
		fstart = 1'b1;
		tick;
		fstart = 1'b0;
		dur = 1;
		while (!(tirq === 1'b1 || rirq === 1'b1 || airq === 1'b1 || nirq === 1'b1) && dur < 30000)
		begin
			tick;
			dur++;
		end
		check_bit("transmit_irq", mode, tirq);
		check_bit("receive_irq", mode & rx, rirq);
		check_bit("ack_irq", !mode & !nk, airq);
		check_bit("nack_irq", !mode & nk, nirq);
		check_bit("ack_received", !nk, ack_rx);
		if (rx)
			check_byte("rx_data", d, rx_data);
		else
			check_byte("slave_byte", exp_q.pop_front(), got);
		check_bit("open_drain", 1'b0, scl_o | sda_o);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge clk_i);
		#2;
		rst_n_i = 1'b1;
		check_bit("rst_lines", 1'b0, m_scl_oe | m_sda_oe | busy);
		cond(0, 20);
		check_bit("start_lines", 1'b1, m_scl_oe & m_sda_oe);
		repeat (2)
		begin
			lfsr = lfsr_next(lfsr);
			frame({lfsr[7:1], 1'b0}, 1'b0, 1'b0, d0);
		end
		for (int i = 0; i < 4; i++)
		begin
			check_bit("idle_before_config", 1'b0, busy);
			presc = 2'(i);
			dly = 5'(dtab[i]);
			baud = 8'(btab[i]);
			tk = 1 << (2 * i);
			dmin = 1000000;
			dmax = 0;
			lfsr = lfsr_next(lfsr);
			frame({lfsr[7:1], 1'b0}, 1'b0, 1'b0, d0);
			check_range("delay_min", dtab[i] * tk, (dtab[i] + 2) * tk + 8, dmin);
			check_range("delay_max", dtab[i] * tk, (dtab[i] + 2) * tk + 8, dmax);
		end
		presc = 2'h0;
		dly = 5'h0D;
		baud = 8'h13;
		mode = 1'b0;
		frame(lfsr[15:8], 1'b0, 1'b1, d0);
		frame(lfsr[23:16], 1'b0, 1'b0, d0);
		lfsr = lfsr_next(lfsr);
		rd_byte = lfsr[7:0];
		cond(1, 60);
		check_bit("restart_lines", 1'b1, m_scl_oe & m_sda_oe);
		rd_mode = 1'b1;
		mode = 1'b1;
		frame(lfsr[7:0], 1'b1, 1'b0, d0);
		mode = 1'b0;
		frame(lfsr[15:8], 1'b1, 1'b1, d0);
		rd_mode = 1'b0;
		cond(1, 60);
		mode = 1'b1;
		frame(lfsr[23:16], 1'b0, 1'b0, d0);
		sync_en = 1'b1;
		frame(lfsr[31:24], 1'b0, 1'b0, d1);
		check_range("sync_lag", d0 + 27, d0 + 144, d1);
		stretch = 10'd100;
		frame(lfsr[30:23], 1'b0, 1'b0, d2);
		check_range("stretch", d1 + 360, d1 + 990, d2);
		stretch = 10'd0;
		hold = 1'b1;
		preq = 1'b1;
		tick;
		preq = 1'b0;
		repeat (300) tick;
		check_bit("stop_waits", 1'b1, preq_o);
		hold = 1'b0;
		wait_cirq(d0);
		check_range("stop_after_wait", 1, 200, d0);
		check_bit("stop_lines", 1'b0, m_scl_oe | m_sda_oe | preq_o);
		finish_test;
	end

	initial
	begin
		#(25.0 * 40000);
		fail_count++;
		finish_test;
	end
endmodule
